// ---- rtl/sads_pkg.sv ----
// sads_pkg: constants and carrier types for the address decode and strobe block.
// assumes a 20-bit system address space and an 8-bit data bus with one parity bit.
package sads_pkg;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 8;
   localparam logic [19:0] ROM_LOW_BASE = 20'hF0000;
   localparam logic [19:0] ROM_LOW_LAST = 20'hF7FFF;
   localparam logic [19:0] ROM_HIGH_BASE = 20'hF8000;
   localparam logic [19:0] ROM_HIGH_LAST = 20'hFFFFF;
   localparam logic [19:0] BANK0_BASE = 20'h00000;
   localparam logic [19:0] BANK0_LAST = 20'h3FFFF;
   localparam logic [19:0] BANK1_BASE = 20'h40000;
   localparam logic [19:0] BANK1_LAST = 20'h7FFFF;
   localparam logic [19:0] PRINTER_BASE = 20'h00378;
   localparam logic [19:0] PRINTER_LAST = 20'h0037F;
   // window of I/O ports that belong to this device itself
   localparam logic [19:0] OWN_IO_BASE = 20'h00000;
   localparam logic [19:0] OWN_IO_LAST = 20'h000FF;
   localparam logic [19:0] ADDR_RESET = 20'h00000;

   // one bus cycle request as seen by the decoder
   typedef struct packed {
      logic mem_read;
      logic mem_write;
      logic io_read;
      logic io_write;
      logic refresh;
   } sads_cmd_t;

   // decoded strobes, all active high inside the block
   typedef struct packed {
      logic rom_low_read_enable;
      logic rom_high_read_enable;
      logic common_row_strobe;
      logic bank0_row_select;
      logic bank1_row_select;
      logic printer_port_select;
      logic buffer_direction;
      logic buffer_output_enable;
   } sads_strobe_t;
endpackage : sads_pkg

// ---- rtl/sads_decode.sv ----
// sads_decode: combinational address decode of one bus cycle into strobes.
// assumes address and command are already registered on core_clk_in.
`timescale 1ns/1ps
module sads_decode (
   // cycle
   input wire logic [19:0] addr_in,
   input wire sads_pkg::sads_cmd_t cmd_in,
   input wire logic dma_cycle_in,
   // strobes
   output sads_pkg::sads_strobe_t strobe_out
);
   function automatic logic in_range(input logic [19:0] a, input logic [19:0] lo,
                                     input logic [19:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction : in_range

   logic mem_any;
   logic io_any;

   always_comb begin
      mem_any = cmd_in.mem_read | cmd_in.mem_write;
      io_any = cmd_in.io_read | cmd_in.io_write;
      strobe_out = '0;
      strobe_out.rom_low_read_enable = cmd_in.mem_read &&
         in_range(addr_in, sads_pkg::ROM_LOW_BASE, sads_pkg::ROM_LOW_LAST);
      strobe_out.rom_high_read_enable = cmd_in.mem_read &&
         in_range(addr_in, sads_pkg::ROM_HIGH_BASE, sads_pkg::ROM_HIGH_LAST);
      strobe_out.common_row_strobe = mem_any | cmd_in.refresh;
      strobe_out.bank0_row_select = cmd_in.refresh | (mem_any &&
         in_range(addr_in, sads_pkg::BANK0_BASE, sads_pkg::BANK0_LAST));
      strobe_out.bank1_row_select = cmd_in.refresh | (mem_any &&
         in_range(addr_in, sads_pkg::BANK1_BASE, sads_pkg::BANK1_LAST));
      strobe_out.printer_port_select = !dma_cycle_in && io_any &&
         in_range(addr_in, sads_pkg::PRINTER_BASE, sads_pkg::PRINTER_LAST);
      // outward when the device side drives the data bus: reads of memory or ports
      strobe_out.buffer_direction = cmd_in.mem_read | cmd_in.io_read;
      strobe_out.buffer_output_enable = !(!dma_cycle_in && cmd_in.io_read &&
         in_range(addr_in, sads_pkg::OWN_IO_BASE, sads_pkg::OWN_IO_LAST));
   end
endmodule : sads_decode

// ---- rtl/sads_parity.sv ----
// sads_parity: odd parity generator for the memory data byte.
// assumes write data is stable while the cycle is decoded.
`timescale 1ns/1ps
module sads_parity #(
   parameter int DATA_W = 8
) (
   // data
   input wire logic [DATA_W-1:0] data_in,
   // parity
   output logic parity_out
);
   always_comb begin
      parity_out = ~(^data_in);
   end
endmodule : sads_parity

// ---- rtl/sads_top.sv ----
// sads_top: address decode, dram row strobes, buffer control, dma ownership
// and system address drive for the system support logic.
// assumes all inputs except reset_in come from pins outside the clock domain and are synchronised here.
// Functional notes
// - drive the common row strobe on every memory access and every refresh.
// - select bank 0 rows for addresses 00000H..3FFFFH and during any refresh.
// - select bank 1 rows for addresses 40000H..7FFFFH and during any refresh.
// - drive buffer direction 1 for outward data and 0 for inward data.
// - keep the buffer enabled except while the processor reads the device's own ports.
// - select the printer controller on processor I/O accesses to 378H..37FH.
// - flag dma bus ownership for as long as the dma controller holds the bus.
// - drive the system address from the processor or, in dma cycles, the dma address.
// - generate memory parity internally and present it toward memory.
// - never check returned parity, so no parity error arises from it.
// - start no dma cycle while the processor bus lock is active.
`timescale 1ns/1ps
module sads_top #(
   parameter int ADDR_W = 20,
   parameter int DATA_W = 8
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic reset_in,
   // processor cycle
   input wire logic [19:0] cpu_addr_in,
   input wire sads_pkg::sads_cmd_t cpu_cmd_in,
   input wire logic bus_lock_in,
   // dma controller
   input wire logic dma_request_in,
   input wire logic [19:0] dma_addr_in,
   input wire sads_pkg::sads_cmd_t dma_cmd_in,
   // memory data
   input wire logic [DATA_W-1:0] write_data_in,
   input wire logic parity_from_memory_in,
   // memory and rom strobes, active low on the pins
   output logic rom_low_read_enable_n_out,
   output logic rom_high_read_enable_n_out,
   output logic common_row_strobe_n_out,
   output logic bank0_row_select_n_out,
   output logic bank1_row_select_n_out,
   output logic bank2_row_select_n_out,
   // buffers and selects
   output logic buffer_direction_out,
   output logic buffer_output_enable_n_out,
   output logic printer_port_select_n_out,
   output logic memory_buffer_enable_n_out,
   output logic nmi_out,
   // bus ownership and address
   output logic dma_owns_bus_out,
   output logic [19:0] system_address_out,
   output logic parity_to_memory_out
);
   // two-flop synchronisers on every pin input except reset_in
   logic [19:0] cpu_addr_s1, cpu_addr_s2;
   logic [19:0] dma_addr_s1, dma_addr_s2;
   sads_pkg::sads_cmd_t cpu_cmd_s1, cpu_cmd_s2, dma_cmd_s1, dma_cmd_s2;
   logic lock_s1, lock_s2, dreq_s1, dreq_s2;
   logic [DATA_W-1:0] wdata_s1, wdata_s2;
   logic par_s1, par_s2;

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         cpu_addr_s1 <= '0;
         cpu_addr_s2 <= '0;
         dma_addr_s1 <= '0;
         dma_addr_s2 <= '0;
         cpu_cmd_s1 <= '0;
         cpu_cmd_s2 <= '0;
         dma_cmd_s1 <= '0;
         dma_cmd_s2 <= '0;
         lock_s1 <= 1'b0;
         lock_s2 <= 1'b0;
         dreq_s1 <= 1'b0;
         dreq_s2 <= 1'b0;
         wdata_s1 <= '0;
         wdata_s2 <= '0;
         par_s1 <= 1'b0;
         par_s2 <= 1'b0;
      end else begin
         cpu_addr_s1 <= cpu_addr_in;
         cpu_addr_s2 <= cpu_addr_s1;
         dma_addr_s1 <= dma_addr_in;
         dma_addr_s2 <= dma_addr_s1;
         cpu_cmd_s1 <= cpu_cmd_in;
         cpu_cmd_s2 <= cpu_cmd_s1;
         dma_cmd_s1 <= dma_cmd_in;
         dma_cmd_s2 <= dma_cmd_s1;
         lock_s1 <= bus_lock_in;
         lock_s2 <= lock_s1;
         dreq_s1 <= dma_request_in;
         dreq_s2 <= dreq_s1;
         wdata_s1 <= write_data_in;
         wdata_s2 <= wdata_s1;
         // returned parity is captured for the record but never compared
         par_s1 <= parity_from_memory_in;
         par_s2 <= par_s1;
      end
   end

   // bus ownership: processor holds the bus unless dma has been granted
   typedef enum logic [1:0] {SADS_CPU, SADS_DMA} sads_owner_t;
   sads_owner_t owner, next_owner;

   always_comb begin
      next_owner = owner;
      case (owner)
         SADS_CPU: begin
            // a locked processor sequence bars the dma from taking the bus
            if (dreq_s2 && !lock_s2) begin
               next_owner = SADS_DMA;
            end
         end
         SADS_DMA: begin
            if (!dreq_s2) begin
               next_owner = SADS_CPU;
            end
         end
         default: next_owner = SADS_CPU;
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         owner <= SADS_CPU;
      end else begin
         owner <= next_owner;
      end
   end

   // cycle selection; a processor command seen during dma is ignored
   logic dma_cycle;
   logic [19:0] cyc_addr;
   sads_pkg::sads_cmd_t cyc_cmd;
   sads_pkg::sads_strobe_t strobe;
   logic parity_bit;

   always_comb begin
      dma_cycle = (owner == SADS_DMA);
      cyc_addr = dma_cycle ? dma_addr_s2 : cpu_addr_s2;
      cyc_cmd = dma_cycle ? dma_cmd_s2 : cpu_cmd_s2;
   end

   sads_decode u_decode (
      .addr_in(cyc_addr),
      .cmd_in(cyc_cmd),
      .dma_cycle_in(dma_cycle),
      .strobe_out(strobe)
   );

   sads_parity #(.DATA_W(DATA_W)) u_parity (
      .data_in(wdata_s2),
      .parity_out(parity_bit)
   );

   // registered outputs; the pins are the flops themselves, so no gate follows them
   sads_pkg::sads_strobe_t next_strobe_q;
   logic next_dma_owns;
   logic [19:0] next_sys_addr;
   logic next_parity_q;

   always_comb begin
      next_strobe_q = strobe;
      next_dma_owns = dma_cycle;
      next_sys_addr = cyc_addr;
      next_parity_q = parity_bit;
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         rom_low_read_enable_n_out <= 1'b1;
         rom_high_read_enable_n_out <= 1'b1;
         common_row_strobe_n_out <= 1'b1;
         bank0_row_select_n_out <= 1'b1;
         bank1_row_select_n_out <= 1'b1;
         buffer_direction_out <= 1'b0;
         buffer_output_enable_n_out <= 1'b0;
         printer_port_select_n_out <= 1'b1;
         dma_owns_bus_out <= 1'b0;
         system_address_out <= sads_pkg::ADDR_RESET;
         parity_to_memory_out <= 1'b0;
      end else begin
         rom_low_read_enable_n_out <= ~next_strobe_q.rom_low_read_enable;
         rom_high_read_enable_n_out <= ~next_strobe_q.rom_high_read_enable;
         common_row_strobe_n_out <= ~next_strobe_q.common_row_strobe;
         bank0_row_select_n_out <= ~next_strobe_q.bank0_row_select;
         bank1_row_select_n_out <= ~next_strobe_q.bank1_row_select;
         buffer_direction_out <= next_strobe_q.buffer_direction;
         buffer_output_enable_n_out <= ~next_strobe_q.buffer_output_enable;
         printer_port_select_n_out <= ~next_strobe_q.printer_port_select;
         dma_owns_bus_out <= next_dma_owns;
         system_address_out <= next_sys_addr;
         parity_to_memory_out <= next_parity_q;
      end
   end

   // unused outputs held at their inactive level, still from flops
   always_ff @(posedge core_clk_in) begin
      bank2_row_select_n_out <= 1'b1;
      memory_buffer_enable_n_out <= 1'b1;
      nmi_out <= 1'b0;
   end

   // helper: registered copy of the decode inputs for one-cycle checks
   sads_pkg::sads_cmd_t cmd_d;
   logic [19:0] addr_d;
   logic dma_d;
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         cmd_d <= '0;
         addr_d <= '0;
         dma_d <= 1'b0;
      end else begin
         cmd_d <= cyc_cmd;
         addr_d <= cyc_addr;
         dma_d <= dma_cycle;
      end
   end

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (reset_in);

   sequence dma_wanted_while_locked;
      dreq_s2 && lock_s2 && owner == SADS_CPU;
   endsequence

   rom_high_read_a: assert property (cmd_d.mem_read && addr_d >= 20'hF8000
      |-> !rom_high_read_enable_n_out && rom_low_read_enable_n_out)
      else $error("high rom enable wrong for read above F8000");
   rom_low_read_a: assert property (cmd_d.mem_read && addr_d >= 20'hF0000
      && addr_d <= 20'hF7FFF |-> !rom_low_read_enable_n_out)
      else $error("low rom enable missing");
   refresh_rows_a: assert property (cmd_d.refresh |-> !common_row_strobe_n_out
      && !bank0_row_select_n_out && !bank1_row_select_n_out)
      else $error("refresh did not strobe all rows");
   bank_split_a: assert property ((cmd_d.mem_read || cmd_d.mem_write) && !cmd_d.refresh
      && addr_d >= 20'h40000 && addr_d <= 20'h7FFFF
      |-> !bank1_row_select_n_out && bank0_row_select_n_out)
      else $error("bank 1 select wrong");
   bank_zero_a: assert property ((cmd_d.mem_read || cmd_d.mem_write)
      && addr_d <= 20'h3FFFF |-> !bank0_row_select_n_out)
      else $error("bank 0 select missing");
   printer_select_a: assert property (!dma_d && cmd_d.io_write && addr_d >= 20'h00378
      && addr_d <= 20'h0037F |-> !printer_port_select_n_out)
      else $error("printer select missing");
   buffer_dir_a: assert property (cmd_d.mem_write && !cmd_d.mem_read && !cmd_d.io_read
      |-> !buffer_direction_out)
      else $error("buffer direction not inward on write");
   buffer_enable_a: assert property (!cmd_d.io_read |-> !buffer_output_enable_n_out)
      else $error("buffer disabled outside own port read");
   lock_blocks_dma_a: assert property (dma_wanted_while_locked
      |=> !dma_owns_bus_out ##1 !dma_owns_bus_out)
      else $error("dma took the bus under lock");
   dma_owner_a: assert property (owner == SADS_DMA |=> dma_owns_bus_out
      && system_address_out == $past(dma_addr_s2))
      else $error("dma ownership or address not shown");
   unused_idle_a: assert property (bank2_row_select_n_out && memory_buffer_enable_n_out
      && !nmi_out)
      else $error("unused output became active");
endmodule : sads_top

// ---- testbench/sads_dma_model.sv ----
// sads_dma_model: behavioural dma controller on the far side of sads_top.
// assumes ownership is reported back on dma_owns_bus_out; drives target and op only while it owns.
`timescale 1ns/1ps
module sads_dma_model (
   // clock
   input wire logic core_clk_in,
   // bench control
   input wire logic want_in,
   input wire logic [19:0] target_in,
   input wire sads_pkg::sads_cmd_t op_in,
   // from the block
   input wire logic owns_in,
   // toward the block
   output logic dma_request_out,
   output logic [19:0] dma_addr_out,
   output sads_pkg::sads_cmd_t dma_cmd_out
);
   initial begin
      dma_request_out = 1'b0;
      dma_addr_out = 20'h00000;
      dma_cmd_out = '0;
   end
   always @(posedge core_clk_in) begin
      dma_request_out <= want_in;
      if (owns_in && want_in) begin
         dma_addr_out <= target_in;
         dma_cmd_out <= op_in;
      end else begin
         // released lines invert the last address every cycle and clear the command
         dma_addr_out <= ~dma_addr_out;
         dma_cmd_out <= '0;
      end
   end
endmodule : sads_dma_model

// ---- testbench/testbench.sv ----
// testbench: self-checking bench for sads_top decode, parity and dma ownership.
// assumes sads_dma_model as the dma side; inputs move 1 ns after each rising edge.
`timescale 1ns/1ps
module testbench;
   logic core_clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic [19:0] cpu_addr = 20'h00000;
   logic [4:0] cpu_cmd = 5'h00;
   logic bus_lock = 1'b0;
   logic dma_want = 1'b0;
   logic [19:0] dma_target = 20'h00000;
   logic [4:0] dma_op = 5'h00;
   logic [7:0] wdata = 8'h00;
   logic par_back = 1'b0;
   logic dma_request;
   logic [19:0] dma_addr;
   sads_pkg::sads_cmd_t dma_cmd;
   logic rl_n, rh_n, crs_n, b0_n, b1_n, b2_n, dir, en_n, prt_n, mbe_n, nmi, owns, par;
   logic [19:0] sys_addr;
   logic [10:0] pins;
   int miscompares = 0;
   int n_checks = 0;
   assign pins = {rl_n, rh_n, crs_n, b0_n, b1_n, b2_n, dir, en_n, prt_n, mbe_n, nmi};
   always #12.5 core_clk_in = ~core_clk_in;
   sads_top dut (.core_clk_in(core_clk_in), .reset_in(reset_in), .cpu_addr_in(cpu_addr),
      .cpu_cmd_in(cpu_cmd), .bus_lock_in(bus_lock), .dma_request_in(dma_request),
      .dma_addr_in(dma_addr), .dma_cmd_in(dma_cmd), .write_data_in(wdata),
      .parity_from_memory_in(par_back), .rom_low_read_enable_n_out(rl_n),
      .rom_high_read_enable_n_out(rh_n), .common_row_strobe_n_out(crs_n),
      .bank0_row_select_n_out(b0_n), .bank1_row_select_n_out(b1_n),
      .bank2_row_select_n_out(b2_n), .buffer_direction_out(dir),
      .buffer_output_enable_n_out(en_n), .printer_port_select_n_out(prt_n),
      .memory_buffer_enable_n_out(mbe_n), .nmi_out(nmi), .dma_owns_bus_out(owns),
      .system_address_out(sys_addr), .parity_to_memory_out(par));
   sads_dma_model dma (.core_clk_in(core_clk_in), .want_in(dma_want), .target_in(dma_target),
      .op_in(dma_op), .owns_in(owns), .dma_request_out(dma_request),
      .dma_addr_out(dma_addr), .dma_cmd_out(dma_cmd));

   // c is {mem_read, mem_write, io_read, io_write, refresh}; d marks a dma cycle
   function automatic logic [10:0] expect_pins(input logic [19:0] a, input logic [4:0] c,
         input logic d);
      logic rd, mem, io;
      rd = c[4];
      mem = c[4] | c[3];
      io = c[2] | c[1];
      return {~(rd && a >= 20'hF0000 && a <= 20'hF7FFF), ~(rd && a >= 20'hF8000),
         ~(mem | c[0]), ~((mem && a <= 20'h3FFFF) | c[0]),
         ~((mem && a >= 20'h40000 && a <= 20'h7FFFF) | c[0]), 1'b1, rd | c[2],
         !d && c[2] && a <= 20'h000FF, ~(!d && io && a >= 20'h00378 && a <= 20'h0037F),
         1'b1, 1'b0};
   endfunction : expect_pins

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : close_out

   task automatic step(input int n);
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask : step

   task automatic check_val(input string what, input logic [23:0] exp, input logic [23:0] got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check_val

   // three edges of latency, one more so the sample is settled
   task automatic cpu_cycle(input logic [19:0] a, input logic [4:0] c);
      cpu_addr = a;
      cpu_cmd = c;
      step(4);
      check_val("strobes", 24'(expect_pins(a, c, 1'b0)), 24'(pins));
      check_val("address", 24'(a), 24'(sys_addr));
   endtask : cpu_cycle

   task automatic wait_owns(input logic v);
      int i;
      for (i = 0; i < 10 && owns !== v; i++) step(1);
      check_val("dma_owns", 24'(v), 24'(owns));
      if (owns !== v) close_out();
   endtask : wait_owns

   task automatic test_reset();
      step(11);
      check_val("reset pins", 24'(11'h7E6), 24'(pins));
      check_val("reset misc", 24'h0, {2'b00, owns, par, sys_addr});
      step(1);
      reset_in = 1'b0;
      $display("test reset done");
   endtask : test_reset

   task automatic test_memory();
      logic [19:0] a [10] = '{20'hF0000, 20'hF7FFF, 20'hF8000, 20'hFFFFF, 20'h00000,
         20'h3FFFF, 20'h40000, 20'h7FFFF, 20'h80000, 20'hEFFFF};
      foreach (a[i]) begin
         cpu_cycle(a[i], 5'h10);
         cpu_cycle(a[i], 5'h08);
      end
      cpu_cycle(20'hF8000, 5'h01);
      cpu_cycle(20'h80000, 5'h01);
      $display("test memory done");
   endtask : test_memory

   task automatic test_io();
      logic [19:0] a [8] = '{20'h00377, 20'h00378, 20'h0037F, 20'h00380, 20'h00010,
         20'h000FF, 20'h00100, 20'h00000};
      foreach (a[i]) begin
         cpu_cycle(a[i], 5'h04);
         cpu_cycle(a[i], 5'h02);
      end
      cpu_cycle(20'h00378, 5'h10);
      cpu_cycle(20'h00010, 5'h00);
      $display("test io done");
   endtask : test_io

   task automatic test_parity();
      logic [7:0] d [6] = '{8'h00, 8'h01, 8'h80, 8'hFF, 8'hA5, 8'h7E};
      foreach (d[i]) begin
         wdata = d[i];
         par_back = ~par_back;
         step(4);
         check_val("parity", 24'(~^d[i]), 24'(par));
         check_val("strobes", 24'(expect_pins(20'h00010, 5'h00, 1'b0)), 24'(pins));
      end
      $display("test parity done");
   endtask : test_parity

   task automatic test_dma();
      // the processor stays idle while the dma controller holds the bus
      cpu_cycle(20'h00378, 5'h00);
      bus_lock = 1'b1;
      dma_want = 1'b1;
      step(10);
      check_val("dma_owns", 24'h0, 24'(owns));
      check_val("address", 24'h00378, 24'(sys_addr));
      bus_lock = 1'b0;
      wait_owns(1'b1);
      bus_lock = 1'b1;
      dma_target = 20'hF8000;
      dma_op = 5'h10;
      step(6);
      check_val("strobes", 24'(expect_pins(20'hF8000, 5'h10, 1'b1)), 24'(pins));
      check_val("address", 24'hF8000, 24'(sys_addr));
      dma_target = 20'h00378;
      dma_op = 5'h04;
      step(6);
      check_val("strobes", 24'(expect_pins(20'h00378, 5'h04, 1'b1)), 24'(pins));
      check_val("dma_owns", 24'h1, 24'(owns));
      dma_want = 1'b0;
      bus_lock = 1'b0;
      wait_owns(1'b0);
      cpu_cycle(20'h40000, 5'h10);
      $display("test dma done");
   endtask : test_dma

   initial begin
      test_reset();
      test_memory();
      test_io();
      test_parity();
      test_dma();
      close_out();
   end
endmodule : testbench
